/* rtl/tcm_timer.sv */
/*
 timer capture match unit: prescaler, 32-bit counter, four captures, four matches.
 assumes control comes as plain ports from software logic on the same clock and that
 capture pins are asynchronous; pin combining is done inside this unit per channel.
*/
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R01] 32-bit counter after 32-bit programmable prescaler
// [R02] count peripheral clock or external clock
// [R03] four captures latch count on edge, irq
// [R04] match may continue counting, optional irq
// [R05] stop match halts counter, optional irq
// [R06] reset match zeroes counter, optional irq
// [R07] match output low, high, toggle or hold
// [R08] event mode uses exactly one capture input
// [R09] external clock at most quarter peripheral clock
// [R10] other capture inputs keep capturing
// [R11] several pins OR/AND into one function
// [R12] count on prescale terminal, match on equality
// [R13] external clock synchronised, one count per edge
module tcm_timer #(
    parameter int unsigned NUM_CH = tcm_pkg::TCM_NUM_CH,
    parameter int unsigned PINS_PER_CH = 2
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire tcm_pkg::tcm_ctrl_t ctrl_i,
    input wire tcm_pkg::tcm_match_cfg_t [NUM_CH-1:0] match_cfg_i,
    input wire tcm_pkg::tcm_cap_cfg_t [NUM_CH-1:0] cap_cfg_i,
    input wire logic [NUM_CH-1:0] cap_and_mode_i,
    input wire logic [NUM_CH*PINS_PER_CH-1:0] capture_input_pin_i,
    input wire logic [NUM_CH-1:0] irq_clear_i,
    output logic [31:0] count_o,
    output logic [31:0] prescale_count_o,
    output logic [NUM_CH*32-1:0] capture_o,
    output logic [NUM_CH-1:0] match_pin_o,
    output logic [NUM_CH*PINS_PER_CH-1:0] match_pin_fan_o,
    output logic [NUM_CH-1:0] match_flag_o,
    output logic [NUM_CH-1:0] cap_flag_o,
    output logic running_o,
    output logic irq_o
);
    typedef struct packed {
        logic [31:0] count;
        logic [31:0] pre;
        logic [NUM_CH-1:0][31:0] cap;
        logic [NUM_CH-1:0] mpin;
        logic [NUM_CH-1:0] mflag;
        logic [NUM_CH-1:0] cflag;
        logic halted;
        logic irq;
    } tcm_state_t;

    tcm_state_t s_q;
    tcm_state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [NUM_CH-1:0] comb_pin;
    logic [NUM_CH-1:0] cap_hit;
    logic [NUM_CH-1:0] evt_hit;
    logic [NUM_CH-1:0] evt_sel;

    function automatic logic apply_ema(input tcm_pkg::tcm_ema_t act, input logic cur);
        unique case (act)
            tcm_pkg::TCM_EMA_NOTHING: apply_ema = cur;
            tcm_pkg::TCM_EMA_LOW: apply_ema = 1'b0;
            tcm_pkg::TCM_EMA_HIGH: apply_ema = 1'b1;
            tcm_pkg::TCM_EMA_TOGGLE: apply_ema = ~cur;
        endcase
    endfunction

    // one step up, wrapping at the top of the count range
    function automatic logic [31:0] incr32(input logic [31:0] v);
        incr32 = v + 32'h0000_0001;
    endfunction

    // reset enters at once, leaves the block two edges after release
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // per-channel pin combining, OR or AND of the assigned pins
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            comb_pin[c] = cap_and_mode_i[c] ?
                &capture_input_pin_i[c*PINS_PER_CH +: PINS_PER_CH] :
                |capture_input_pin_i[c*PINS_PER_CH +: PINS_PER_CH]; // [R11]
        end
    end

    // only the selected channel feeds the counter in event mode
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            evt_sel[c] = (ctrl_i.mode == tcm_pkg::TCM_MODE_EVENT) &&
                (ctrl_i.event_sel == 2'(c)); // [R08]
        end
    end

    for (genvar g = 0; g < NUM_CH; g++) begin : g_sync
        tcm_edge_sync u_cap_sync (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n),
            .clk_en_i(clk_en_i),
            .pin_i(comb_pin[g]),
            .edge_sel_i(cap_cfg_i[g].edge_sel),
            .hit_o(cap_hit[g])
        );
        tcm_edge_sync u_evt_sync (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n),
            .clk_en_i(clk_en_i),
            .pin_i(comb_pin[g]),
            .edge_sel_i(evt_sel[g] ? ctrl_i.event_edge : tcm_pkg::TCM_EDGE_NONE), // [R13]
            .hit_o(evt_hit[g])
        );
    end

    always_comb begin
        logic tick;
        logic cnt_tick;
        logic [NUM_CH-1:0] hit;
        tick = 1'b0;
        cnt_tick = 1'b0;
        hit = '0;
        s_d = s_q;
        if (clk_en_i) begin
            // source of prescaler ticks
            if (ctrl_i.mode == tcm_pkg::TCM_MODE_TIMER) begin
                tick = 1'b1; // [R02]
            end else begin
                tick = |evt_hit; // [R02] [R13]
            end
            for (int c = 0; c < NUM_CH; c++) begin
                hit[c] = (s_q.count == match_cfg_i[c].value); // [R12]
            end
            if (ctrl_i.count_reset) begin
                s_d.count = tcm_pkg::TCM_COUNT_RST;
                s_d.pre = tcm_pkg::TCM_PRESCALE_RST;
                s_d.halted = 1'b0;
            end else if (ctrl_i.enable && !s_q.halted && tick) begin
                if (s_q.pre >= ctrl_i.prescale) begin
                    s_d.pre = tcm_pkg::TCM_PRESCALE_RST;
                    cnt_tick = 1'b1; // [R01] [R12]
                end else begin
                    s_d.pre = incr32(s_q.pre); // [R01]
                end
            end
            // match actions are taken when the matching count is about to advance
            if (cnt_tick) begin
                s_d.count = incr32(s_q.count); // [R04]
                for (int c = 0; c < NUM_CH; c++) begin
                    if (hit[c]) begin
                        if (match_cfg_i[c].reset_en) begin
                            s_d.count = tcm_pkg::TCM_COUNT_RST; // [R06]
                        end
                    end
                end
                for (int c = 0; c < NUM_CH; c++) begin
                    if (hit[c]) begin
                        s_d.mpin[c] = apply_ema(match_cfg_i[c].action, s_q.mpin[c]); // [R07]
                        if (match_cfg_i[c].stop_en) begin
                            s_d.count = s_q.count; // [R05]
                            s_d.pre = tcm_pkg::TCM_PRESCALE_RST;
                            s_d.halted = 1'b1; // [R05]
                        end
                    end
                end
            end
            // flags: clear first, a new event wins
            for (int c = 0; c < NUM_CH; c++) begin
                if (irq_clear_i[c]) begin
                    s_d.mflag[c] = 1'b0;
                    s_d.cflag[c] = 1'b0;
                end
                if (cnt_tick && hit[c] && match_cfg_i[c].irq_en) begin
                    s_d.mflag[c] = 1'b1; // [R04] [R05] [R06]
                end
                // every channel keeps capturing, even the one counting events
                if (cap_hit[c]) begin
                    s_d.cap[c] = s_q.count; // [R03] [R10]
                    if (cap_cfg_i[c].irq_en) begin
                        s_d.cflag[c] = 1'b1; // [R03]
                    end
                end
            end
            s_d.irq = |{s_d.mflag, s_d.cflag};
        end
    end

    // one register stage holds all counter, capture and match state
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            capture_o[c*32 +: 32] = s_q.cap[c];
            match_pin_fan_o[c*PINS_PER_CH +: PINS_PER_CH] = {PINS_PER_CH{s_q.mpin[c]}}; // [R11]
        end
    end

    // every output is a register bit, except running_o, which is the inverse of one
    assign count_o = s_q.count;
    assign prescale_count_o = s_q.pre;
    assign match_pin_o = s_q.mpin;
    assign match_flag_o = s_q.mflag;
    assign cap_flag_o = s_q.cflag;
    assign running_o = ~s_q.halted;
    assign irq_o = s_q.irq;
endmodule
`default_nettype wire

/* rtl/tcm_pkg.sv */
/*
 timer capture match unit package: widths, counts, match actions, control and configuration carriers.
 assumes a single 200 MHz peripheral clock domain.
*/
package tcm_pkg;
    localparam int unsigned TCM_NUM_CH = 4;
    localparam int unsigned TCM_CNT_W = 32;
    localparam int unsigned TCM_SYNC_STAGES = 3;
    localparam logic [31:0] TCM_COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] TCM_PRESCALE_RST = 32'h0000_0000;
    localparam logic [3:0] TCM_MATCH_PIN_RST = 4'h0;
    localparam int unsigned TCM_CLK_PERIOD_NS = 5;

    // counting source
    typedef enum logic [0:0] {
        TCM_MODE_TIMER = 1'b0,
        TCM_MODE_EVENT = 1'b1
    } tcm_mode_t;

    // which edges of a capture or counting input qualify
    typedef enum logic [1:0] {
        TCM_EDGE_NONE = 2'b00,
        TCM_EDGE_RISE = 2'b01,
        TCM_EDGE_FALL = 2'b10,
        TCM_EDGE_BOTH = 2'b11
    } tcm_edge_t;

    // external output action on a match
    typedef enum logic [1:0] {
        TCM_EMA_NOTHING = 2'b00,
        TCM_EMA_LOW = 2'b01,
        TCM_EMA_HIGH = 2'b10,
        TCM_EMA_TOGGLE = 2'b11
    } tcm_ema_t;

    typedef struct packed {
        logic enable;
        logic count_reset;
        tcm_mode_t mode;
        logic [1:0] event_sel;
        tcm_edge_t event_edge;
        logic [31:0] prescale;
    } tcm_ctrl_t;

    typedef struct packed {
        logic irq_en;
        logic stop_en;
        logic reset_en;
        tcm_ema_t action;
        logic [31:0] value;
    } tcm_match_cfg_t;

    typedef struct packed {
        logic irq_en;
        tcm_edge_t edge_sel;
    } tcm_cap_cfg_t;
endpackage

/* rtl/tcm_edge_sync.sv */
/*
 three-stage synchroniser with edge qualification for one external pin.
 assumes pin is asynchronous to sys_clk_i; freezes while clk_en_i is low.
*/
`timescale 1ns/100ps
`default_nettype none
module tcm_edge_sync (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic pin_i,
    input wire tcm_pkg::tcm_edge_t edge_sel_i,
    output logic hit_o
);
    typedef struct packed {
        logic [2:0] sync;
        logic [2:0] primed;
    } tcm_sync_state_t;

    tcm_sync_state_t s_q;
    tcm_sync_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (clk_en_i) begin
            s_d.sync = {s_q.sync[1:0], pin_i};
            s_d.primed = {s_q.primed[1:0], 1'b1};
        end
    end

    // stage 0 feeds only stage 1; stages 1 and 2 differing mark an edge
    // no edge until stage 2 holds a real sample, so reset makes no false edge
    always_comb begin
        hit_o = 1'b0;
        if (clk_en_i && s_q.primed[2]) begin
            unique case (edge_sel_i)
                tcm_pkg::TCM_EDGE_NONE: hit_o = 1'b0;
                tcm_pkg::TCM_EDGE_RISE: hit_o = s_q.sync[1] & ~s_q.sync[2];
                tcm_pkg::TCM_EDGE_FALL: hit_o = ~s_q.sync[1] & s_q.sync[2];
                tcm_pkg::TCM_EDGE_BOTH: hit_o = s_q.sync[1] ^ s_q.sync[2];
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

/* bench/tcm_timer_chk.sv */
/*
 port checker for tcm_timer, bound into every instance.
 assumes one clock domain and the ports as tcm_timer declares them.
*/
`timescale 1ns/100ps
`default_nettype none
module tcm_timer_chk #(
    parameter int unsigned NUM_CH = 4,
    parameter int unsigned PINS_PER_CH = 2
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire tcm_pkg::tcm_ctrl_t ctrl_i,
    input wire tcm_pkg::tcm_match_cfg_t [NUM_CH-1:0] match_cfg_i,
    input wire logic [31:0] count_o,
    input wire logic [31:0] prescale_count_o,
    input wire logic [NUM_CH-1:0] match_pin_o,
    input wire logic [NUM_CH*PINS_PER_CH-1:0] match_pin_fan_o,
    input wire logic [NUM_CH-1:0] match_flag_o,
    input wire logic [NUM_CH-1:0] cap_flag_o,
    input wire logic running_o,
    input wire logic irq_o
);
    logic run_t;
    logic tick;
    logic pin_nx;
    logic [NUM_CH-1:0] hit;
    logic [NUM_CH-1:0] stop_hit;
    logic [NUM_CH-1:0] rs_hit;
    logic [NUM_CH*PINS_PER_CH-1:0] fan_exp;
    assign run_t = clk_en_i && ctrl_i.enable && !ctrl_i.count_reset && running_o
        && ctrl_i.mode == tcm_pkg::TCM_MODE_TIMER;
    assign tick = run_t && prescale_count_o == ctrl_i.prescale;
    assign pin_nx = match_cfg_i[0].action == tcm_pkg::TCM_EMA_LOW ? 1'b0
        : match_cfg_i[0].action == tcm_pkg::TCM_EMA_HIGH ? 1'b1
        : match_cfg_i[0].action == tcm_pkg::TCM_EMA_TOGGLE ? ~match_pin_o[0] : match_pin_o[0];
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            hit[c] = tick && count_o == match_cfg_i[c].value;
            stop_hit[c] = hit[c] && match_cfg_i[c].stop_en;
            rs_hit[c] = stop_hit[c] || (hit[c] && match_cfg_i[c].reset_en);
            for (int p = 0; p < PINS_PER_CH; p++) begin
                fan_exp[c*PINS_PER_CH+p] = match_pin_o[c];
            end
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_prescale_step: assert property (
        run_t && prescale_count_o < ctrl_i.prescale
        |=> prescale_count_o == $past(prescale_count_o) + 32'h1 && $stable(count_o))
        else $error("prescale step wrong");
    a_count_advance: assert property (
        tick && !(|rs_hit) |=> count_o == $past(count_o) + 32'h1 && prescale_count_o == 32'h0)
        else $error("counter did not advance");
    a_match_reset: assert property (
        hit[0] && match_cfg_i[0].reset_en && !(|stop_hit) |=> count_o == 32'h0)
        else $error("reset match did not zero");
    a_match_stop: assert property (
        |stop_hit |=> !running_o && $stable(count_o))
        else $error("stop match did not halt");
    a_match_action: assert property (
        hit[0] |=> match_pin_o[0] == $past(pin_nx))
        else $error("match pin action wrong");
    a_fan_copy: assert property (
        match_pin_fan_o == fan_exp)
        else $error("fan pins differ");
    a_irq_or: assert property (
        irq_o == (|{match_flag_o, cap_flag_o}))
        else $error("irq not or of flags");
    a_match_flag: assert property (
        hit[0] && match_cfg_i[0].irq_en |=> match_flag_o[0])
        else $error("match flag not set");
endmodule
bind tcm_timer tcm_timer_chk #(.NUM_CH(NUM_CH), .PINS_PER_CH(PINS_PER_CH)) tcm_timer_chk_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .ctrl_i(ctrl_i),
    .match_cfg_i(match_cfg_i), .count_o(count_o), .prescale_count_o(prescale_count_o),
    .match_pin_o(match_pin_o), .match_pin_fan_o(match_pin_fan_o),
    .match_flag_o(match_flag_o), .cap_flag_o(cap_flag_o), .running_o(running_o), .irq_o(irq_o));
`default_nettype wire

/* bench/tcm_pin_model.sv */
/*
 external pin model: slow counting clock on pin 0, other pins follow the bench.
 assumes run_i and lvl_i change just after the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tcm_pin_model (
    input wire logic sys_clk_i,
    input wire logic run_i,
    input wire logic [7:0] lvl_i,
    output logic [7:0] pin_o
);
    logic [1:0] ph_q = 2'h0;
    logic ext_q = 1'b0;
    // two cycles per level, a quarter of the clock; stands still outside runs
    always @(posedge sys_clk_i) begin
        if (run_i) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q[0]) begin
                ext_q <= ~ext_q;
            end
        end
    end
    assign pin_o = {lvl_i[7:1], ext_q};
endmodule
`default_nettype wire

/* bench/testbench.sv */
/*
 self-checking bench for tcm_timer with an external pin model.
 assumes a 200 MHz clock and inputs driven after the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n, clk_en, run, running, irq;
    logic [7:0] lvl, pins, fan;
    tcm_pkg::tcm_ctrl_t ctrl;
    tcm_pkg::tcm_match_cfg_t [3:0] mc;
    tcm_pkg::tcm_cap_cfg_t [3:0] cc;
    logic [3:0] and_m, clr, mpin, mflag, cflag;
    logic [31:0] cnt, pcnt;
    logic [127:0] cap;
    int fail_count = 0;
    int tests_run = 0;
    int p, m, n, k;
    always #2.5 clk = ~clk;
    tcm_pin_model tcm_pin_model_i (.sys_clk_i(clk), .run_i(run), .lvl_i(lvl), .pin_o(pins));
    tcm_timer tcm_timer_i (.sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(clk_en),
        .ctrl_i(ctrl), .match_cfg_i(mc), .cap_cfg_i(cc), .cap_and_mode_i(and_m),
        .capture_input_pin_i(pins), .irq_clear_i(clr), .count_o(cnt),
        .prescale_count_o(pcnt), .capture_o(cap), .match_pin_o(mpin),
        .match_pin_fan_o(fan), .match_flag_o(mflag), .cap_flag_o(cflag),
        .running_o(running), .irq_o(irq));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        run = 1'b0;
        lvl = 8'h00;
        and_m = 4'h8;
        clr = 4'h0;
        ctrl = '0;
        ctrl.count_reset = 1'b1;
        mc = '0;
        cc = '0;
        void'($urandom(369));
        p = 1 + $urandom % 3;
        m = 5 + $urandom % 4;
        cyc(4);
        rst_n = 1'b1;
        cyc(4);
        // prescaled timer count, then frozen clock enable
        ctrl.prescale = 32'(p);
        ctrl.enable = 1'b1;
        ctrl.count_reset = 1'b0;
        cyc(6 * (p + 1));
        chk("count", 32'h6, cnt);
        clk_en = 1'b0;
        cyc(3);
        clk_en = 1'b1;
        chk("frozen count", 32'h6, cnt);
        chk("prescale", 32'h0, pcnt);
        // reset match with toggle, high, low and hold on the other channels
        ctrl.prescale = 32'h0;
        ctrl.count_reset = 1'b1;
        mc[0].value = 32'(m);
        mc[0].reset_en = 1'b1;
        mc[0].irq_en = 1'b1;
        mc[0].action = tcm_pkg::TCM_EMA_TOGGLE;
        mc[1].value = 32'h2;
        mc[1].action = tcm_pkg::TCM_EMA_HIGH;
        mc[2].value = 32'h3;
        mc[2].action = tcm_pkg::TCM_EMA_LOW;
        cyc(1);
        ctrl.count_reset = 1'b0;
        n = 3 * (m + 1) + 1;
        cyc(n);
        chk("count", 32'(n % (m + 1)), cnt);
        chk("match pins", 32'h3, 32'(mpin));
        chk("match flag", 32'h1, 32'(mflag));
        // stop match halts at its value
        mc[1].stop_en = 1'b1;
        cyc(m + 3);
        chk("stopped count", 32'h2, cnt);
        chk("running", 32'h0, 32'(running));
        // captures on a halted counter, or and and of pins
        cc[2].edge_sel = tcm_pkg::TCM_EDGE_RISE;
        cc[2].irq_en = 1'b1;
        cc[3] = cc[2];
        lvl = 8'h60;
        cyc(5);
        chk("capture 2", 32'h2, cap[95:64]);
        chk("cap flags", 32'h4, 32'(cflag));
        lvl = 8'hE0;
        cyc(5);
        chk("cap flags", 32'hC, 32'(cflag));
        chk("capture 3", 32'h2, cap[127:96]);
        clr = 4'hF;
        lvl = 8'h00;
        cyc(1);
        clr = 4'h0;
        cyc(5);
        chk("irq", 32'h0, 32'(irq));
        // event counting on pin 0 while channel 2 still captures
        mc[1].stop_en = 1'b0;
        mc[0].reset_en = 1'b0;
        ctrl.mode = tcm_pkg::TCM_MODE_EVENT;
        ctrl.event_sel = 2'h0;
        ctrl.event_edge = tcm_pkg::TCM_EDGE_RISE;
        cc[1].edge_sel = tcm_pkg::TCM_EDGE_FALL;
        cc[1].irq_en = 1'b1;
        cc[3].edge_sel = tcm_pkg::TCM_EDGE_BOTH;
        ctrl.count_reset = 1'b1;
        cyc(1);
        ctrl.count_reset = 1'b0;
        k = 3 + $urandom % 4;
        run = 1'b1;
        lvl = 8'hC4;
        cyc(4 * k);
        run = 1'b0;
        cyc(4);
        chk("capture 3", 32'h0, cap[127:96]);
        lvl = 8'h10;
        cyc(5);
        chk("event count", 32'(k), cnt);
        chk("capture 2", 32'(k), cap[95:64]);
        chk("capture 1", 32'(k), cap[63:32]);
        chk("capture 3", 32'(k), cap[127:96]);
        chk("cap flags", 32'hE, 32'(cflag));
        tally_and_finish();
    end
endmodule
`default_nettype wire
